// [verilog/scl_consts.vh]
// Strap layout, mode codes, advertisement bits and register map of the strap latch
`ifndef SCL_CONSTS_VH
`define SCL_CONSTS_VH
`define SCL_ADDR_W        5
`define SCL_PORTS         4
`define SCL_LEDS          8
`define SCL_MODE_W        5
`define SCL_ADDR_MAX      5'h1C
`define SCL_BCAST_ADDR    5'h00
`define SCL_SYNC_WAIT     2'h2
`define SCL_PORT_ADDR_RST 20'h18820
// Mode code fields
`define SCL_MODE_AN_BIT   4
`define SCL_MODE_EEE_BIT  3
`define SCL_MODE_SUB_W    3
`define SCL_SUB_ALL_S     3'h0
`define SCL_SUB_ALL_M     3'h1
`define SCL_SUB_G_S       3'h2
`define SCL_SUB_G_M       3'h3
`define SCL_SUB_100       3'h4
`define SCL_SUB_100FD     3'h5
`define SCL_SUB_100HD     3'h6
`define SCL_SUB_100_10    3'h7
// Advertisement vector bit positions
`define SCL_ADV_W         9
`define SCL_ADV_1000FD    0
`define SCL_ADV_MULTI     1
`define SCL_ADV_1000EEE   2
`define SCL_ADV_100FD     3
`define SCL_ADV_100HD     4
`define SCL_ADV_100EEE    5
`define SCL_ADV_10FD      6
`define SCL_ADV_10HD      7
`define SCL_ADV_PAUSE     8
// Cable class encoding
`define SCL_CAB_NA        2'h0
`define SCL_CAB_CAT3      2'h1
`define SCL_CAB_CAT5      2'h2
// APB register map (byte addresses)
`define SCL_REG_STRAP     12'h000
`define SCL_REG_MODE      12'h004
`define SCL_REG_CTRL      12'h008
`define SCL_REG_PORTADDR  12'h00C
`define SCL_CTRL_BCAST    0
`define SCL_CTRL_LEDSTY   1
`endif

// [verilog/scl_mode_decode.v]
// Decoder from device mode strap code to per-port functional defaults
`default_nettype none
`include "scl_consts.vh"
module scl_mode_decode (
  input  wire [`SCL_MODE_W-1:0] mode_i,
  output reg  [`SCL_ADV_W-1:0]  adv_o,
  output reg                    an_en_o,
  output reg                    amdix_en_o,
  output reg                    eee_en_o,
  output reg  [1:0]             cable_o,
  output reg                    reserved_o
);
  wire [`SCL_MODE_SUB_W-1:0] sub = mode_i[`SCL_MODE_SUB_W-1:0];
  wire                       eee = mode_i[`SCL_MODE_EEE_BIT];
  wire                       ten;
  assign ten = (sub == `SCL_SUB_ALL_S) || (sub == `SCL_SUB_ALL_M) ||
               (sub == `SCL_SUB_100_10);

  always @* begin
    adv_o      = {`SCL_ADV_W{1'b0}};
    an_en_o    = 1'b0;
    amdix_en_o = 1'b0;
    eee_en_o   = 1'b0;
    cable_o    = `SCL_CAB_NA;
    reserved_o = 1'b0;
    if (!mode_i[`SCL_MODE_AN_BIT] || mode_i == 5'h1E) begin
      reserved_o = 1'b1;
    end else begin
      an_en_o                 = 1'b1;
      amdix_en_o              = 1'b1;
      eee_en_o                = eee;
      adv_o[`SCL_ADV_PAUSE]   = 1'b1;
      // Gigabit is only ever full duplex: no half-duplex bit exists
      case (sub)
        `SCL_SUB_ALL_S, `SCL_SUB_ALL_M, `SCL_SUB_G_S, `SCL_SUB_G_M: begin
          adv_o[`SCL_ADV_1000FD]  = 1'b1;
          adv_o[`SCL_ADV_MULTI]   = sub[0];
          adv_o[`SCL_ADV_1000EEE] = eee;
        end
        default: begin
        end
      endcase
      case (sub)
        `SCL_SUB_ALL_S, `SCL_SUB_ALL_M, `SCL_SUB_100, `SCL_SUB_100_10: begin
          adv_o[`SCL_ADV_100FD] = 1'b1;
          adv_o[`SCL_ADV_100HD] = 1'b1;
        end
        `SCL_SUB_100FD: adv_o[`SCL_ADV_100FD] = 1'b1;
        `SCL_SUB_100HD: adv_o[`SCL_ADV_100HD] = 1'b1;
        default: begin
        end
      endcase
      adv_o[`SCL_ADV_100EEE] = eee &
        (adv_o[`SCL_ADV_100FD] | adv_o[`SCL_ADV_100HD]);
      adv_o[`SCL_ADV_10FD]   = ten;
      adv_o[`SCL_ADV_10HD]   = ten;
      if (ten) begin
        cable_o = eee ? `SCL_CAB_CAT5 : `SCL_CAB_CAT3;
      end
    end
  end
endmodule // scl_mode_decode
`default_nettype wire

// [verilog/scl_strap_latch.v]
// Strap latch: captures configuration straps at reset release and decodes defaults
// How it works
// - Capture all straps when chip reset rises; hold them until next reset, except broadcast enable, which software may rewrite.
// - Latch five-bit management base address; pulled-up reads 1, pulled-down 0.
// - Port n answers base address plus n, for n from 0 to 3.
// - LED strap 0 gives polarity bit 1; strap 1 gives polarity 0.
// - Broadcast strap 0 enables address-zero access by default; 1 disables.
// - With broadcast enabled, every port also answers address zero.
// - LED style strap 0 is tri-color, 1 individual, same for all LEDs.
// - Five-bit device mode latched and applied alike to all four ports.
// - No mode advertises gigabit half duplex.
// - Codes 10000-10111: autoneg, auto-MDIX, no EEE, both pause types.
// - Codes 11000-11111 except reserved 11110: as above plus EEE on gigabit and 100 abilities.
// - 10000/10001 advertise all speeds, single/multi port, cable class cat3.
// - 1x010/1x011 advertise gigabit full only; cable class not applicable.
`default_nettype none
`include "scl_consts.vh"
module scl_strap_latch (
  input  wire                                clk_i,
  input  wire                                rst_n_i,
  input  wire [`SCL_ADDR_W-1:0]              mgmt_base_addr_strap_i,
  input  wire [`SCL_LEDS-1:0]                led_polarity_strap_i,
  input  wire                                broadcast_addr_strap_i,
  input  wire                                led_style_strap_i,
  input  wire [`SCL_MODE_W-1:0]              mode_strap_i,
  input  wire [`SCL_ADDR_W-1:0]              mdio_addr_i,
  input  wire                                psel_i,
  input  wire                                penable_i,
  input  wire                                pwrite_i,
  input  wire [11:0]                         paddr_i,
  input  wire [31:0]                         pwdata_i,
  output wire [31:0]                         prdata_o,
  output wire                                pready_o,
  output wire                                pslverr_o,
  output wire                                strap_valid_o,
  output wire [`SCL_ADDR_W-1:0]              mgmt_base_addr_o,
  output wire [`SCL_PORTS*`SCL_ADDR_W-1:0]   port_addr_o,
  output wire [`SCL_PORTS-1:0]               port_addr_hit_o,
  output wire [`SCL_LEDS-1:0]                led_polarity_o,
  output wire                                bcast_en_o,
  output wire                                led_individual_o,
  output wire [`SCL_MODE_W-1:0]              mode_o,
  output wire [`SCL_ADV_W-1:0]               adv_o,
  output wire                                an_en_o,
  output wire                                amdix_en_o,
  output wire                                eee_en_o,
  output wire [1:0]                          cable_class_o,
  output wire                                mode_reserved_o,
  output wire                                base_addr_range_err_o
);
  localparam ST_RESET   = 3'h1;
  localparam ST_CAPTURE = 3'h2;
  localparam ST_VALID   = 3'h4;

  localparam SW = `SCL_ADDR_W + `SCL_LEDS + 2 + `SCL_MODE_W;

  // Strap pins come from the board: two-flop synchroniser before any use
  reg  [SW-1:0]            sync1_ff;
  reg  [SW-1:0]            sync2_ff;
  reg  [2:0]               state_ff;
  reg  [2:0]               nxt_state;
  reg  [`SCL_ADDR_W-1:0]   base_ff;
  reg  [`SCL_LEDS-1:0]     ledpol_ff;
  reg                      bcast_ff;
  reg                      ledsty_ff;
  reg  [`SCL_MODE_W-1:0]   mode_ff;
  reg  [`SCL_ADDR_W-1:0]   mdio_s1_ff;
  reg  [`SCL_ADDR_W-1:0]   mdio_s2_ff;
  reg  [31:0]              rdata_ff;
  reg  [31:0]              nxt_rdata;
  reg                      rsel_err;

  wire [SW-1:0] straps_in = {mgmt_base_addr_strap_i, led_polarity_strap_i,
                             broadcast_addr_strap_i, led_style_strap_i, mode_strap_i};
  wire          capture   = (state_ff == ST_CAPTURE);
  wire          valid     = (state_ff == ST_VALID);

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `SCL_REG_STRAP) || (a == `SCL_REG_MODE) ||
                  (a == `SCL_REG_CTRL) || (a == `SCL_REG_PORTADDR);
    end
  endfunction

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff   <= {SW{1'b0}};
      sync2_ff   <= {SW{1'b0}};
      mdio_s1_ff <= {`SCL_ADDR_W{1'b0}};
      mdio_s2_ff <= {`SCL_ADDR_W{1'b0}};
    end else begin
      sync1_ff   <= straps_in;
      sync2_ff   <= sync1_ff;
      mdio_s1_ff <= mdio_addr_i;
      mdio_s2_ff <= mdio_s1_ff;
    end
  end

  // Sequencer: wait out the synchroniser after release, then capture once
  reg [1:0] wait_ff;
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET:   if (wait_ff == `SCL_SYNC_WAIT) nxt_state = ST_CAPTURE;
      ST_CAPTURE: nxt_state = ST_VALID;
      ST_VALID:   nxt_state = ST_VALID;
      default:    nxt_state = ST_RESET;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_RESET;
      wait_ff  <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (wait_ff != `SCL_SYNC_WAIT) begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end

  // Strap capture happens once after reset release; all but the broadcast enable hold until next reset
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      base_ff   <= {`SCL_ADDR_W{1'b0}};
      ledpol_ff <= {`SCL_LEDS{1'b0}};
      bcast_ff  <= 1'b0;
      ledsty_ff <= 1'b0;
      mode_ff   <= {`SCL_MODE_W{1'b0}};
    end else if (capture) begin
      {base_ff, ledpol_ff, bcast_ff, ledsty_ff, mode_ff} <= sync2_ff;
    end else if (valid && psel_i && penable_i && pwrite_i &&
                 paddr_i == `SCL_REG_CTRL) begin
      // Software may override the broadcast enable default
      bcast_ff <= ~pwdata_i[`SCL_CTRL_BCAST];
    end
  end

  // Next values of the port-side outputs; only the port address offsets show before the capture completes
  wire [`SCL_LEDS-1:0]              nxt_ledpol;
  wire                              nxt_bcast;
  wire                              nxt_ledind;
  wire                              nxt_rerr;
  wire [`SCL_PORTS*`SCL_ADDR_W-1:0] nxt_port_addr;
  wire [`SCL_PORTS-1:0]             nxt_hit;

  assign nxt_ledpol = valid ? ~ledpol_ff : {`SCL_LEDS{1'b0}};
  assign nxt_bcast  = valid & ~bcast_ff;
  assign nxt_ledind = valid & ledsty_ff;
  assign nxt_rerr   = valid & (base_ff > `SCL_ADDR_MAX);

  // Each port answers its own address and, with broadcast on, address zero
  genvar p;
  generate
    for (p = 0; p < `SCL_PORTS; p = p + 1) begin : g_port
      wire [`SCL_ADDR_W-1:0] pa = base_ff + p[`SCL_ADDR_W-1:0];
      assign nxt_port_addr[p*`SCL_ADDR_W +: `SCL_ADDR_W] = pa;
      assign nxt_hit[p] = valid & ((mdio_s2_ff == pa) ||
        (nxt_bcast && mdio_s2_ff == `SCL_BCAST_ADDR));
    end
  endgenerate

  wire [`SCL_ADV_W-1:0] dec_adv;
  wire                  dec_an;
  wire                  dec_amdix;
  wire                  dec_eee;
  wire [1:0]            dec_cab;
  wire                  dec_res;

  scl_mode_decode u_dec (
    .mode_i     (mode_ff),
    .adv_o      (dec_adv),
    .an_en_o    (dec_an),
    .amdix_en_o (dec_amdix),
    .eee_en_o   (dec_eee),
    .cable_o    (dec_cab),
    .reserved_o (dec_res)
  );

  // Decoded mode reaches ports only once the capture has completed
  wire [`SCL_ADV_W-1:0] nxt_adv;
  wire                  nxt_an;
  wire                  nxt_amdix;
  wire                  nxt_eee;
  wire [1:0]            nxt_cab;
  wire                  nxt_res;

  assign nxt_adv   = valid ? dec_adv : {`SCL_ADV_W{1'b0}};
  assign nxt_an    = valid & dec_an;
  assign nxt_amdix = valid & dec_amdix;
  assign nxt_eee   = valid & dec_eee;
  assign nxt_cab   = valid ? dec_cab : `SCL_CAB_NA;
  assign nxt_res   = valid & dec_res;

  // Port-side outputs leave from flip-flops
  // All of them trail the latch by one cycle, so they stay consistent with each other
  reg                               out_valid_ff;
  reg  [`SCL_ADDR_W-1:0]            out_base_ff;
  reg  [`SCL_PORTS*`SCL_ADDR_W-1:0] out_paddr_ff;
  reg  [`SCL_PORTS-1:0]             out_hit_ff;
  reg  [`SCL_LEDS-1:0]              out_ledpol_ff;
  reg                               out_bcast_ff;
  reg                               out_ledind_ff;
  reg  [`SCL_MODE_W-1:0]            out_mode_ff;
  reg  [`SCL_ADV_W-1:0]             out_adv_ff;
  reg                               out_an_ff;
  reg                               out_amdix_ff;
  reg                               out_eee_ff;
  reg  [1:0]                        out_cab_ff;
  reg                               out_res_ff;
  reg                               out_rerr_ff;

  // Port addresses show the bare offsets while in reset
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_valid_ff  <= 1'b0;
      out_base_ff   <= {`SCL_ADDR_W{1'b0}};
      out_paddr_ff  <= `SCL_PORT_ADDR_RST;
      out_hit_ff    <= {`SCL_PORTS{1'b0}};
      out_ledpol_ff <= {`SCL_LEDS{1'b0}};
      out_bcast_ff  <= 1'b0;
      out_ledind_ff <= 1'b0;
      out_mode_ff   <= {`SCL_MODE_W{1'b0}};
      out_adv_ff    <= {`SCL_ADV_W{1'b0}};
      out_an_ff     <= 1'b0;
      out_amdix_ff  <= 1'b0;
      out_eee_ff    <= 1'b0;
      out_cab_ff    <= `SCL_CAB_NA;
      out_res_ff    <= 1'b0;
      out_rerr_ff   <= 1'b0;
    end else begin
      out_valid_ff  <= valid;
      out_base_ff   <= base_ff;
      out_paddr_ff  <= nxt_port_addr;
      out_hit_ff    <= nxt_hit;
      out_ledpol_ff <= nxt_ledpol;
      out_bcast_ff  <= nxt_bcast;
      out_ledind_ff <= nxt_ledind;
      out_mode_ff   <= mode_ff;
      out_adv_ff    <= nxt_adv;
      out_an_ff     <= nxt_an;
      out_amdix_ff  <= nxt_amdix;
      out_eee_ff    <= nxt_eee;
      out_cab_ff    <= nxt_cab;
      out_res_ff    <= nxt_res;
      out_rerr_ff   <= nxt_rerr;
    end
  end

  assign strap_valid_o         = out_valid_ff;
  assign mgmt_base_addr_o      = out_base_ff;
  assign port_addr_o           = out_paddr_ff;
  assign port_addr_hit_o       = out_hit_ff;
  assign led_polarity_o        = out_ledpol_ff;
  assign bcast_en_o            = out_bcast_ff;
  assign led_individual_o      = out_ledind_ff;
  assign mode_o                = out_mode_ff;
  assign adv_o                 = out_adv_ff;
  assign an_en_o               = out_an_ff;
  assign amdix_en_o            = out_amdix_ff;
  assign eee_en_o              = out_eee_ff;
  assign cable_class_o         = out_cab_ff;
  assign mode_reserved_o       = out_res_ff;
  assign base_addr_range_err_o = out_rerr_ff;

  // APB read path: answer registered in the setup cycle, zero wait states
  always @* begin
    rsel_err  = !is_mapped(paddr_i);
    nxt_rdata = 32'h00000000;
    case (paddr_i)
      `SCL_REG_STRAP:
        nxt_rdata = {16'h0000, base_ff, ledpol_ff, bcast_ff, ledsty_ff, valid};
      `SCL_REG_MODE:
        nxt_rdata = {12'h000, dec_res, dec_cab, dec_eee, dec_amdix, dec_an,
                     dec_adv, mode_ff};
      `SCL_REG_CTRL:
        nxt_rdata = {30'h00000000, ledsty_ff, ~bcast_ff};
      `SCL_REG_PORTADDR:
        nxt_rdata = {12'h000, nxt_port_addr};
      default:
        nxt_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata_o  = rdata_ff;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & rsel_err;
endmodule // scl_strap_latch
`default_nettype wire

// [bench/scl_board.sv]
// Board model: strap resistors and the LED drive that takes the pins over later
`default_nettype none
module scl_board (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] base_i,
  input  wire logic [7:0] led_i,
  input  wire logic       bc_i,
  input  wire logic       sty_i,
  input  wire logic [4:0] mode_i,
  output logic      [4:0] base_o,
  output logic      [7:0] led_o,
  output logic            bc_o,
  output logic            sty_o,
  output logic      [4:0] mode_o,
  output logic            bad_cfg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  logic       drv;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
    end else if (cnt_ff != 4'hF) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // Straps stand past capture, then the pins carry other levels
  assign drv    = !rst_n_i || cnt_ff < 4'h6;
  assign base_o = drv ? base_i : ~base_i;
  assign led_o  = drv ? led_i : ~led_i;
  assign bc_o   = drv ? bc_i : ~bc_i;
  assign sty_o  = drv ? sty_i : ~sty_i;
  assign mode_o = drv ? mode_i : ~mode_i;
  // Strappings the board must avoid
  assign bad_cfg_o = base_i > 5'h1C || !mode_i[4] || mode_i == 5'h1E;
endmodule // scl_board
`default_nettype wire

// [bench/scl_strap_latch_sva.sv]
// Checker of strap capture, hold and decode at the latch ports
`default_nettype none
module scl_strap_latch_sva (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  mdio_addr_i,
  input wire logic        strap_valid_o,
  input wire logic [4:0]  mgmt_base_addr_o,
  input wire logic [19:0] port_addr_o,
  input wire logic [3:0]  port_addr_hit_o,
  input wire logic [7:0]  led_polarity_o,
  input wire logic        bcast_en_o,
  input wire logic        led_individual_o,
  input wire logic [4:0]  mode_o,
  input wire logic [8:0]  adv_o,
  input wire logic        an_en_o,
  input wire logic        amdix_en_o,
  input wire logic        eee_en_o,
  input wire logic        mode_reserved_o,
  input wire logic        base_addr_range_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !strap_valid_o && port_addr_hit_o == 4'h0) else $error("Reset left outputs set");
  valid_rise_a: assert property (
    $rose(rst_n_i) |-> ##[1:6] strap_valid_o) else $error("Capture did not complete");
  hold_stable_a: assert property (
    strap_valid_o && $past(strap_valid_o) |-> $stable(mgmt_base_addr_o) && $stable(mode_o)
    && $stable(led_polarity_o) && $stable(led_individual_o)) else $error("Latched value moved");
  port_addr_a: assert property (
    strap_valid_o |-> port_addr_o == {5'(mgmt_base_addr_o + 5'h03), 5'(mgmt_base_addr_o + 5'h02),
    5'(mgmt_base_addr_o + 5'h01), mgmt_base_addr_o}) else $error("Port address wrong");
  invalid_zero_a: assert property (
    !strap_valid_o |-> led_polarity_o == 8'h00 && adv_o == 9'h000 && port_addr_hit_o == 4'h0
    && mgmt_base_addr_o == 5'h00) else $error("Output acted on before capture");
  no_eee_a: assert property (
    strap_valid_o && mode_o[4:3] == 2'h2 |-> an_en_o && amdix_en_o && !eee_en_o && adv_o[8]
    && !adv_o[2] && !adv_o[5]) else $error("Non-EEE mode decode wrong");
  eee_on_a: assert property (
    strap_valid_o && mode_o[4:3] == 2'h3 && mode_o != 5'h1E |-> an_en_o && amdix_en_o && eee_en_o
    && adv_o[8] && adv_o[2] == adv_o[0] && adv_o[5] == (adv_o[3] | adv_o[4])) else $error("EEE mode wrong");
  bcast_hit_a: assert property (
    strap_valid_o && bcast_en_o && $past(bcast_en_o) && $past(mdio_addr_i, 2) == 5'h00
    && $past(mdio_addr_i, 3) == 5'h00 |-> port_addr_hit_o == 4'hF) else $error("Broadcast miss");
  range_flag_a: assert property (
    strap_valid_o |-> base_addr_range_err_o == (mgmt_base_addr_o > 5'h1C)) else $error("Range flag wrong");
  reserved_flag_a: assert property (
    strap_valid_o |-> mode_reserved_o == (!mode_o[4] || mode_o == 5'h1E)) else $error("Reserved flag wrong");
endmodule // scl_strap_latch_sva
bind scl_strap_latch scl_strap_latch_sva u_sva (.clk_i, .rst_n_i, .mdio_addr_i, .strap_valid_o,
  .mgmt_base_addr_o, .port_addr_o, .port_addr_hit_o, .led_polarity_o, .bcast_en_o,
  .led_individual_o, .mode_o, .adv_o, .an_en_o, .amdix_en_o, .eee_en_o, .mode_reserved_o,
  .base_addr_range_err_o);
`default_nettype wire

// [bench/scl_strap_latch_tb_top.sv]
// Testbench of the strap latch: mode sweep, broadcast matching, register access
`default_nettype none
module scl_strap_latch_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, cfg_bc = 1'b0, cfg_sty = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [4:0]  cfg_base = 5'h00, cfg_mode = 5'h18, mdio_addr_i = 5'h00;
  logic [7:0]  cfg_led = 8'h00, led_s, led_polarity_o;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [4:0]  base_s, mode_s, mgmt_base_addr_o, mode_o;
  logic        bc_s, sty_s, pready_o, pslverr_o, strap_valid_o, bcast_en_o, led_individual_o;
  logic        an_en_o, amdix_en_o, eee_en_o, mode_reserved_o, base_addr_range_err_o, err;
  logic [19:0] port_addr_o;
  logic        bad_cfg;
  logic [3:0]  port_addr_hit_o;
  logic [8:0]  adv_o;
  logic [1:0]  cable_class_o;
  int          miscompares = 0, samples_checked = 0;
  localparam logic [8:0] adv_tbl [16] = '{9'h1D9, 9'h1DB, 9'h101, 9'h103, 9'h118, 9'h108, 9'h110,
    9'h1D8, 9'h1FD, 9'h1FF, 9'h105, 9'h107, 9'h138, 9'h128, 9'h000, 9'h1F8};
  localparam logic [1:0] cab_tbl [16] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2,
    2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  always #25 clk_i = ~clk_i;
  scl_board u_board (.clk_i, .rst_n_i, .base_i(cfg_base), .led_i(cfg_led), .bc_i(cfg_bc),
    .sty_i(cfg_sty), .mode_i(cfg_mode), .base_o(base_s), .led_o(led_s), .bc_o(bc_s),
    .sty_o(sty_s), .mode_o(mode_s), .bad_cfg_o(bad_cfg));
  scl_strap_latch DUT (.clk_i, .rst_n_i, .mgmt_base_addr_strap_i(base_s), .led_polarity_strap_i(led_s),
    .broadcast_addr_strap_i(bc_s), .led_style_strap_i(sty_s), .mode_strap_i(mode_s), .mdio_addr_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .strap_valid_o, .mgmt_base_addr_o, .port_addr_o, .port_addr_hit_o, .led_polarity_o, .bcast_en_o,
    .led_individual_o, .mode_o, .adv_o, .an_en_o, .amdix_en_o, .eee_en_o, .cable_class_o,
    .mode_reserved_o, .base_addr_range_err_o);
  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic do_reset(input logic [4:0] b, input logic [7:0] l, input logic bc, st,
                          input logic [4:0] m);
    int n;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    {cfg_base, cfg_led, cfg_bc, cfg_sty, cfg_mode} <= {b, l, bc, st, m};
    repeat (10) @(posedge clk_i);
    chk("valid_in_reset", 1'b0, strap_valid_o);
    rst_n_i <= 1'b1;
    n = 0;
    while (strap_valid_o !== 1'b1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    chk("valid_rise", 1'b1, strap_valid_o);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic sweep_modes;
    logic [4:0] m;
    logic [7:0] lp;
    for (int i = 0; i < 32; i++) begin
      m = 5'(i);
      lp = {m, 3'h5};
      do_reset(m, lp, m[0], m[1], m);
      lp = ~lp;
      chk("base", m, mgmt_base_addr_o);
      chk("port_addr", {5'(m + 5'h03), 5'(m + 5'h02), 5'(m + 5'h01), m}, port_addr_o);
      chk("led_pol", lp, led_polarity_o);
      chk("bcast_en", !m[0], bcast_en_o);
      chk("led_style", m[1], led_individual_o);
      chk("mode", m, mode_o);
      chk("adv", m[4] ? adv_tbl[m[3:0]] : 9'h000, adv_o);
      chk("cable", m[4] ? cab_tbl[m[3:0]] : 2'h0, cable_class_o);
      chk("eee", m[4] && m[3] && m != 5'h1E, eee_en_o);
      chk("autoneg", m[4] && m != 5'h1E, an_en_o);
      chk("reserved", !m[4] || m == 5'h1E, mode_reserved_o);
      chk("range_err", m > 5'h1C, base_addr_range_err_o);
    end
  endtask
  task automatic bcast_match;
    do_reset(5'h04, 8'h3C, 1'b0, 1'b0, 5'h18);
    chk("board_cfg_ok", 1'b0, bad_cfg);
    mdio_addr_i <= 5'h00;
    repeat (5) @(posedge clk_i);
    chk("hit_bcast", 4'hF, port_addr_hit_o);
    mdio_addr_i <= 5'h06;
    repeat (5) @(posedge clk_i);
    chk("hit_port2", 4'h4, port_addr_hit_o);
    apb(1'b1, 12'h008, 32'h0, rd, err);
    mdio_addr_i <= 5'h00;
    repeat (5) @(posedge clk_i);
    chk("bcast_off", 1'b0, bcast_en_o);
    chk("hit_none", 4'h0, port_addr_hit_o);
  endtask
  task automatic apb_access;
    do_reset(5'h0A, 8'h5A, 1'b1, 1'b1, 5'h19);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk("reg_strap", {16'h0, 5'h0A, 8'h5A, 3'h7}, rd);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk("reg_mode", {12'h0, 3'h2, 3'h7, 9'h1FF, 5'h19}, rd);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("reg_ctrl", 32'h2, rd);
    apb(1'b1, 12'h008, 32'h1, rd, err);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk("ctrl_write", 32'h3, rd);
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("reg_port", {12'h0, 5'h0D, 5'h0C, 5'h0B, 5'h0A}, rd);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_rd", 32'h0, rd);
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
  initial begin
    sweep_modes();
    bcast_match();
    apb_access();
    give_verdict();
  end
endmodule // scl_strap_latch_tb_top
`default_nettype wire
